/* File: core/efc_decoder.sv */
// Edge decoder for the encoder inputs of the feedback counter.
// Assumes encA and encB are already synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module efc_decoder (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Encoder pins
  input  wire logic       encA,
  input  wire logic       encB,
  // Configuration
  input  wire logic [1:0] encType,
  input  wire logic [1:0] rateSel,
  // Count pulses
  output logic            countUp,
  output logic            countDn
);
  import efc_pkg::*;

  typedef struct packed {
    logic prevA;
    logic prevB;
    logic up;
    logic dn;
  } efc_dec_s;

  efc_dec_s st_r;
  efc_dec_s st_nxt;

  always_comb begin
    logic edgeA;
    logic edgeB;
    edgeA = 1'b0;
    edgeB = 1'b0;
    st_nxt = st_r;
    st_nxt.prevA = encA;
    st_nxt.prevB = encB;
    st_nxt.up = 1'b0;
    st_nxt.dn = 1'b0;
    edgeA = encA ^ st_r.prevA;
    edgeB = encB ^ st_r.prevB;
    case (encType)
      EFC_TYPE_UP_DOWN: begin
        // Both pins rising together is illegal for this encoder; it is dropped.
        st_nxt.up = encA & ~st_r.prevA & ~(encB & ~st_r.prevB); // see RULE7
        st_nxt.dn = encB & ~st_r.prevB & ~(encA & ~st_r.prevA); // see RULE7
      end
      EFC_TYPE_TWO_PHASE_MARKER, EFC_TYPE_TWO_PHASE_NO_MARK: begin
        // A change on both phases at once has no direction and is dropped.
        if (edgeA && !edgeB) begin
          if (rateSel == 2'd0) begin
            // Single rate: rising A only; B low means A leads.
            st_nxt.up = encA & ~encB; // see RULE4
            st_nxt.dn = encA & encB; // see RULE4
          end else begin
            st_nxt.up = (encA != encB); // see RULE5
            st_nxt.dn = (encA == encB); // see RULE5
          end
        end else if (edgeB && !edgeA && rateSel == 2'd2) begin
          st_nxt.up = (encA == encB); // see RULE5
          st_nxt.dn = (encA != encB); // see RULE5
        end
      end
      default: begin
        st_nxt.up = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign countUp = st_r.up;
  assign countDn = st_r.dn;

endmodule
`default_nettype wire

/* File: core/efc_pkg.sv */
// Package of the encoder feedback counter: register map, field layout,
// reset values, encoder type codes and timing constants.
// Assumes a single 250 MHz clock and a 32-bit AHB-Lite register bus.
package efc_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned EFC_CLK_MHZ       = 250;
  localparam int unsigned EFC_STALL_WIN_US  = 1000;
  localparam int unsigned EFC_STALL_WIN_CYC = EFC_STALL_WIN_US * EFC_CLK_MHZ;
  localparam int unsigned EFC_STALL_PCT_DIV = 10;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] EFC_OFS_CONFIG  = 8'h00;
  localparam logic [7:0] EFC_OFS_CONTROL = 8'h04;
  localparam logic [7:0] EFC_OFS_SETPOS  = 8'h08;
  localparam logic [7:0] EFC_OFS_MOT_LO  = 8'h0C;
  localparam logic [7:0] EFC_OFS_MOT_HI  = 8'h10;
  localparam logic [7:0] EFC_OFS_ENC_LO  = 8'h14;
  localparam logic [7:0] EFC_OFS_ENC_HI  = 8'h18;
  localparam logic [7:0] EFC_OFS_STATUS  = 8'h1C;
  localparam logic [7:0] EFC_OFS_IRQ_ST  = 8'h20;
  localparam logic [7:0] EFC_OFS_IRQ_MSK = 8'h24;
  localparam logic [7:0] EFC_OFS_MARKER  = 8'h28;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned EFC_CFG_TYPE_LSB = 0;
  localparam int unsigned EFC_CFG_MULT_LSB = 8;
  localparam int unsigned EFC_CFG_DIV_LSB  = 16;
  localparam int unsigned EFC_CFG_TOL_LSB  = 24;
  localparam int unsigned EFC_CTL_SETPOS   = 0;
  localparam int unsigned EFC_CTL_CLRERR   = 1;
  localparam int unsigned EFC_ST_VALID     = 0;
  localparam int unsigned EFC_ST_STALL     = 1;
  localparam int unsigned EFC_ST_INHIBIT   = 2;
  localparam int unsigned EFC_IRQ_STALL    = 0;
  localparam int unsigned EFC_IRQ_INVALID  = 1;
  localparam int unsigned EFC_IRQ_MARKER   = 2;

  // ----------------------------------------------------------------------
  // Encoder type codes and value limits
  // ----------------------------------------------------------------------
  localparam logic [1:0] EFC_TYPE_NONE              = 2'h0;
  localparam logic [1:0] EFC_TYPE_TWO_PHASE_MARKER  = 2'h1;
  localparam logic [1:0] EFC_TYPE_UP_DOWN           = 2'h2;
  localparam logic [1:0] EFC_TYPE_TWO_PHASE_NO_MARK = 2'h3;
  localparam logic [7:0] EFC_MULT_MIN = 8'h01;
  localparam logic [4:0] EFC_DIV_MIN  = 5'h01;
  localparam logic [4:0] EFC_DIV_MAX  = 5'h10;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] EFC_RST_TYPE = EFC_TYPE_NONE;
  localparam logic [7:0] EFC_RST_MULT = 8'h01;
  localparam logic [4:0] EFC_RST_DIV  = 5'h01;
  localparam logic [7:0] EFC_RST_TOL  = 8'h00;

endpackage

/* File: core/efc_top.sv */
// Encoder feedback counter: decodes encoder pulses, scales them to step
// units, validates the motor position and detects a stalled motor.
// Assumes step pulses come one cycle long from an outside step generator
// which honours stepInhibit, and a single AHB-Lite master.
//
// Function
// RULE1: Encoder type selects one of four behaviours.
// RULE2: No feedback type never raises stall flag.
// RULE3: Other types update encoder position from pulses.
// RULE4: Two-phase direction from which phase lags.
// RULE5: Double or quadruple rate from multiplier multiple.
// RULE6: Marker on home input gives reference position.
// RULE7: Up/down: A increments, B decrements count.
// RULE8: Up/down encoder drives only one output.
// RULE9: Multiplier 1 to 255, divisor 1 to 16.
// RULE10: Step-to-encoder ratio scales encoder counts; up/down type uses multEff, a half or quarter of an even multiplier.
// RULE11: Configure the smallest reduced ratio pair.
// RULE12: Difference beyond tolerance clears position valid.
// RULE13: Validation mismatch never stops the move.
// RULE14: Velocity below tenth: stop steps, flag stall.
// RULE15: Signed position in two words, low first.
`timescale 1ns/10ps
`default_nettype none
module efc_top #(
  parameter int unsigned STALL_WIN_CYC = efc_pkg::EFC_STALL_WIN_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Encoder and home pins
  input  wire logic        encA,
  input  wire logic        encB,
  input  wire logic        homeIn,
  // Step generator side
  input  wire logic        stepPulse,
  input  wire logic        stepDirUp,
  output logic             stepInhibit,
  // Status
  output logic             positionValidFlag,
  output logic             motorStallErrorFlag,
  output logic             irq
);
  import efc_pkg::*;

  if (STALL_WIN_CYC < 2) begin : g_chk
    $error("STALL_WIN_CYC must be at least 2");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  encType;
    logic [7:0]  mult;
    logic [4:0]  div;
    logic [7:0]  tol;
    logic [31:0] setPos;
    logic [31:0] motPos;
    logic [31:0] encPos;
    logic [3:0]  frac;
    logic [31:0] markPos;
    logic [15:0] shadowMot;
    logic [15:0] shadowEnc;
    logic        valid;
    logic        stall;
    logic        inhibit;
    logic [2:0]  irqStat;
    logic [2:0]  irqMask;
    logic        irq;
    logic [31:0] winCnt;
    logic [15:0] stepCnt;
    logic [15:0] encCnt;
    logic        homePrev;
    logic        wrPend;
    logic [7:0]  wrAddr;
    logic [31:0] rdata;
    logic        readyOut;
  } efc_state_s;

  efc_state_s st_r;
  efc_state_s st_nxt;

  logic       countUp;
  logic       countDn;
  logic [1:0] rateSel;
  logic [7:0] multEff;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Quotient in the upper nine bits, remainder in the lower four.
  function automatic logic [12:0] divMod(input logic [8:0] a, input logic [4:0] d);
    logic [8:0] q;
    logic [8:0] r;
    q = a / {4'h0, d};
    r = a % {4'h0, d};
    return {q, r[3:0]};
  endfunction

  function automatic logic [15:0] satAdd(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[16] ? 16'hFFFF : s[15:0];
  endfunction

  // ----------------------------------------------------------------------
  // Decoder
  // ----------------------------------------------------------------------
  // The rate follows the multiplier so the two-phase scaled ratio stays unchanged; up/down types get half or a quarter of it when the multiplier is even.
  always_comb begin
    if (st_r.mult[1:0] == 2'b00) begin
      rateSel = 2'd2; // see RULE5
      multEff = {2'b00, st_r.mult[7:2]};
    end else if (st_r.mult[0] == 1'b0) begin
      rateSel = 2'd1; // see RULE5
      multEff = {1'b0, st_r.mult[7:1]};
    end else begin
      rateSel = 2'd0;
      multEff = st_r.mult;
    end
  end

  efc_decoder u_dec (
    .clk     (clk),
    .nrst    (nrst),
    .encA    (encA),
    .encB    (encB),
    .encType (st_r.encType),
    .rateSel (rateSel),
    .countUp (countUp),
    .countDn (countDn)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic        acc;
    logic        rdAcc;
    logic        feedback;
    logic [8:0]  sum;
    logic [12:0] qr;
    logic [3:0]  mirror;
    logic [31:0] diff;
    logic [31:0] absDiff;
    logic [2:0]  irqEv;
    logic [2:0]  irqClr;
    logic        clrErr;
    logic        setCmd;
    logic        winEnd;
    logic [19:0] encScaled;
    logic [15:0] encStep;
    acc = 1'b0;
    rdAcc = 1'b0;
    feedback = 1'b0;
    sum = '0;
    qr = '0;
    mirror = '0;
    diff = '0;
    absDiff = '0;
    irqEv = '0;
    irqClr = '0;
    clrErr = 1'b0;
    setCmd = 1'b0;
    winEnd = 1'b0;
    encScaled = '0;
    encStep = '0;
    st_nxt = st_r;
    st_nxt.readyOut = 1'b1;
    st_nxt.homePrev = homeIn;
    feedback = (st_r.encType != EFC_TYPE_NONE); // see RULE1

    // Bus data phase of a write taken in the previous cycle.
    st_nxt.wrPend = 1'b0;
    if (st_r.wrPend) begin
      case (st_r.wrAddr)
        EFC_OFS_CONFIG: begin
          // Out of range multiplier or divisor refuses the whole write.
          if (hwdata[EFC_CFG_MULT_LSB +: 8] >= EFC_MULT_MIN &&
              hwdata[EFC_CFG_DIV_LSB +: 5] >= EFC_DIV_MIN &&
              hwdata[EFC_CFG_DIV_LSB +: 5] <= EFC_DIV_MAX &&
              hwdata[EFC_CFG_DIV_LSB + 5 +: 3] == 3'b000) begin // see RULE9
            st_nxt.encType = hwdata[EFC_CFG_TYPE_LSB +: 2];
            st_nxt.mult = hwdata[EFC_CFG_MULT_LSB +: 8];
            st_nxt.div = hwdata[EFC_CFG_DIV_LSB +: 5];
            st_nxt.tol = hwdata[EFC_CFG_TOL_LSB +: 8];
            st_nxt.frac = 4'h0;
          end
        end
        EFC_OFS_CONTROL: begin
          setCmd = hwdata[EFC_CTL_SETPOS];
          clrErr = hwdata[EFC_CTL_CLRERR];
        end
        EFC_OFS_SETPOS: begin
          st_nxt.setPos = hwdata;
        end
        EFC_OFS_IRQ_MSK: begin
          st_nxt.irqMask = hwdata[2:0];
        end
        default: begin
          st_nxt.wrPend = 1'b0;
        end
      endcase
    end

    // Bus address phase; reads answer in the following data phase.
    acc = hsel & hready & htrans[1];
    rdAcc = acc & ~hwrite;
    if (acc && hwrite) begin
      st_nxt.wrPend = 1'b1;
      st_nxt.wrAddr = haddr[7:0];
    end
    if (rdAcc) begin
      case (haddr[7:0])
        EFC_OFS_CONFIG: begin
          st_nxt.rdata = {st_r.tol, 3'b000, st_r.div, st_r.mult, 6'h00, st_r.encType};
        end
        EFC_OFS_SETPOS: st_nxt.rdata = st_r.setPos;
        EFC_OFS_MOT_LO: begin
          st_nxt.rdata = {16'h0000, st_r.motPos[15:0]};
          st_nxt.shadowMot = st_r.motPos[31:16]; // see RULE15
        end
        EFC_OFS_MOT_HI: st_nxt.rdata = {16'h0000, st_r.shadowMot};
        EFC_OFS_ENC_LO: begin
          st_nxt.rdata = {16'h0000, st_r.encPos[15:0]};
          st_nxt.shadowEnc = st_r.encPos[31:16]; // see RULE15
        end
        EFC_OFS_ENC_HI: st_nxt.rdata = {16'h0000, st_r.shadowEnc};
        EFC_OFS_STATUS: begin
          st_nxt.rdata = {29'h0, st_r.inhibit, st_r.stall, st_r.valid};
        end
        EFC_OFS_IRQ_ST: begin
          st_nxt.rdata = {29'h0, st_r.irqStat};
          irqClr = st_r.irqStat;
        end
        EFC_OFS_IRQ_MSK: st_nxt.rdata = {29'h0, st_r.irqMask};
        EFC_OFS_MARKER: st_nxt.rdata = st_r.markPos;
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Motor position follows the step pulses in either direction.
    if (stepPulse) begin
      st_nxt.motPos = stepDirUp ? st_r.motPos + 32'h0000_0001
                                : st_r.motPos - 32'h0000_0001;
      st_nxt.stepCnt = satAdd(st_r.stepCnt, 16'h0001);
    end

    // Encoder counts carry multiplier/divisor step units with remainder.
    if (feedback && countUp) begin
      sum = {5'h00, st_r.frac} + {1'b0, multEff};
      qr = divMod(sum, st_r.div); // see RULE10
      st_nxt.encPos = st_r.encPos + {23'h0, qr[12:4]}; // see RULE3
      st_nxt.frac = qr[3:0];
      encStep = {7'h00, qr[12:4]};
    end else if (feedback && countDn) begin
      // Going down is going up in the mirrored remainder.
      mirror = 4'(st_r.div - 5'h01) - st_r.frac;
      sum = {5'h00, mirror} + {1'b0, multEff};
      qr = divMod(sum, st_r.div); // see RULE10
      st_nxt.encPos = st_r.encPos - {23'h0, qr[12:4]}; // see RULE3
      st_nxt.frac = 4'(st_r.div - 5'h01) - qr[3:0];
      encStep = {7'h00, qr[12:4]};
    end
    st_nxt.encCnt = satAdd(st_r.encCnt, encStep);

    // Marker edge on the home input latches a reference position.
    if (st_r.encType == EFC_TYPE_TWO_PHASE_MARKER && homeIn && !st_r.homePrev) begin
      st_nxt.markPos = st_r.encPos; // see RULE6
      irqEv[EFC_IRQ_MARKER] = 1'b1;
    end

    // Validation only clears the flag; the move carries on.
    diff = st_r.motPos - st_r.encPos;
    absDiff = diff[31] ? 32'h0000_0000 - diff : diff;
    if (feedback && st_r.tol != 8'h00 && absDiff > {24'h00_0000, st_r.tol}) begin
      st_nxt.valid = 1'b0; // see RULE12, RULE13
      irqEv[EFC_IRQ_INVALID] = st_r.valid;
    end

    // Velocity check over a fixed window of clock cycles.
    winEnd = (st_r.winCnt == 32'(STALL_WIN_CYC - 1));
    st_nxt.winCnt = winEnd ? 32'h0000_0000 : st_r.winCnt + 32'h0000_0001;
    if (winEnd) begin
      st_nxt.stepCnt = 16'h0000;
      st_nxt.encCnt = 16'h0000;
      encScaled = {4'h0, st_r.encCnt} * 20'(EFC_STALL_PCT_DIV);
      if (feedback && st_r.tol != 8'h00 && st_r.stepCnt != 16'h0000 &&
          encScaled < {4'h0, st_r.stepCnt}) begin // see RULE2, RULE14
        st_nxt.stall = 1'b1;
        st_nxt.inhibit = 1'b1; // see RULE14
        irqEv[EFC_IRQ_STALL] = 1'b1;
      end
    end

    // A stall found in the same cycle survives the clear.
    if (clrErr && !irqEv[EFC_IRQ_STALL]) begin
      st_nxt.stall = 1'b0;
      st_nxt.inhibit = 1'b0;
    end
    if (setCmd) begin
      st_nxt.motPos = st_r.setPos;
      st_nxt.encPos = st_r.setPos;
      st_nxt.frac = 4'h0;
      st_nxt.valid = 1'b1;
      irqEv[EFC_IRQ_INVALID] = 1'b0;
    end

    // Sticky interrupt bits: a new event wins over the read clear.
    st_nxt.irqStat = (st_r.irqStat & ~irqClr) | irqEv;
    st_nxt.irq = |(st_nxt.irqStat & st_nxt.irqMask);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.encType <= EFC_RST_TYPE;
      st_r.mult <= EFC_RST_MULT;
      st_r.div <= EFC_RST_DIV;
      st_r.tol <= EFC_RST_TOL;
      st_r.readyOut <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hrdata = st_r.rdata;
  assign hreadyout = st_r.readyOut;
  assign hresp = 1'b0;
  assign stepInhibit = st_r.inhibit;
  assign positionValidFlag = st_r.valid;
  assign motorStallErrorFlag = st_r.stall;
  assign irq = st_r.irq;

endmodule
`default_nettype wire

/* File: testbench/efc_enc_model.sv */
// Behavioural incremental encoder driving the two encoder phases.
// Assumes the bench calls one task at a time, right after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module efc_enc_model (
  // Clock
  input  wire logic clk,
  // Encoder phases
  output var logic  encA,
  output var logic  encB
);
  int hold = 2;

  initial begin
    encA = 1'b0;
    encB = 1'b0;
  end

  // Gives the decoder pipeline time to land the last count.
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask

  // Gray sequence a quarter period per change; the lagging phase gives direction.
  task automatic quad(input int n, input bit up);
    for (int i = 0; i < 4 * n; i++) begin
      repeat (hold) @(posedge clk);
      if ((encA == encB) == up)
        encA <= !encA;
      else
        encB <= !encB;
    end
    settle();
  endtask

  // Only one output is ever active.
  task automatic ud(input int n, input bit up);
    for (int i = 0; i < n; i++) begin
      repeat (hold) @(posedge clk);
      encA <= up;
      encB <= !up;
      repeat (hold) @(posedge clk);
      encA <= 1'b0;
      encB <= 1'b0;
    end
    settle();
  endtask
endmodule
`default_nettype wire

/* File: testbench/efc_top_props.sv */
// Checker of the encoder feedback counter, bound to the top module's ports.
// Assumes one AHB-Lite master and the bind at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module efc_top_props
  import efc_pkg::*;
#(
  parameter int unsigned STALL_WIN_CYC = EFC_STALL_WIN_CYC
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Steps and status
  input wire logic        stepPulse,
  input wire logic        stepInhibit,
  input wire logic        positionValidFlag,
  input wire logic        motorStallErrorFlag
);
  logic        wrPend_r;
  logic [7:0]  wrAddr_r;
  logic [1:0]  cfgType_r;
  logic [7:0]  cfgTol_r;
  int unsigned idle_r;
  logic        rdTake;
  logic        okCfg;
  logic        clrErr;

  assign rdTake = hsel && hready && htrans[1] && !hwrite;
  assign clrErr = wrPend_r && wrAddr_r == EFC_OFS_CONTROL && hwdata[1];
  assign okCfg  = wrPend_r && wrAddr_r == EFC_OFS_CONFIG && hwdata[15:8] != 8'h00 &&
                  hwdata[23:16] != 8'h00 && hwdata[23:16] <= 8'h10;

  // Shadow of the accepted configuration; a refused write leaves it alone.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrPend_r  <= 1'b0;
      wrAddr_r  <= 8'h00;
      cfgType_r <= EFC_TYPE_NONE;
      cfgTol_r  <= 8'h00;
      idle_r    <= STALL_WIN_CYC + 8;
    end else begin
      wrPend_r <= hsel && hready && htrans[1] && hwrite;
      wrAddr_r <= haddr[7:0];
      if (okCfg) begin
        cfgType_r <= hwdata[1:0];
        cfgTol_r  <= hwdata[31:24];
      end
      idle_r <= stepPulse ? 0 : (idle_r > STALL_WIN_CYC + 8 ? idle_r : idle_r + 1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("Bus answer not ready or not OKAY.");
  a_rdata_hold: assert property (!rdTake |=> $stable(hrdata))
    else $error("Read data changed without a read.");
  a_none_no_stall: assert property (
    $rose(motorStallErrorFlag) |-> $past(cfgType_r) != EFC_TYPE_NONE)
    else $error("Stall raised with no feedback type.");
  a_stall_tol: assert property (
    $rose(motorStallErrorFlag) |-> $past(cfgTol_r) != 8'h00)
    else $error("Stall raised with zero tolerance.");
  a_stall_steps: assert property (
    $rose(motorStallErrorFlag) |-> idle_r <= STALL_WIN_CYC + 4)
    else $error("Stall raised without recent steps.");
  a_inhibit_flag: assert property (stepInhibit == motorStallErrorFlag)
    else $error("Step inhibit differs from stall flag.");
  a_stall_sticky: assert property (
    motorStallErrorFlag && !clrErr |=> motorStallErrorFlag)
    else $error("Stall flag dropped without clear.");
  a_valid_tol: assert property (
    $fell(positionValidFlag) |-> $past(cfgTol_r) != 8'h00 && $past(cfgType_r) != EFC_TYPE_NONE)
    else $error("Valid cleared with validation off.");
  a_valid_no_stop: assert property (
    $fell(positionValidFlag) && !motorStallErrorFlag |-> !stepInhibit)
    else $error("Validation loss stopped the steps.");
endmodule

bind efc_top efc_top_props #(.STALL_WIN_CYC(STALL_WIN_CYC)) i_efc_top_props (
  .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .stepPulse(stepPulse), .stepInhibit(stepInhibit), .positionValidFlag(positionValidFlag),
  .motorStallErrorFlag(motorStallErrorFlag));
`default_nettype wire

/* File: testbench/testbench.sv */
// Testbench of the encoder feedback counter: AHB-Lite tasks and scenarios.
// Assumes the encoder model and the bound checker are compiled beforehand.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import efc_pkg::*;
  localparam int unsigned WIN = 64;
  logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, d;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, encA, encB, irq;
  logic        homeIn = 1'b0, stepPulse = 1'b0, stepDirUp = 1'b0;
  logic        stepInhibit, positionValidFlag, motorStallErrorFlag;
  // Reduced ratio pairs only.
  logic [7:0]  mt [5] = '{8'h01, 8'h02, 8'h04, 8'h03, 8'h01};
  logic [4:0]  dv [5] = '{5'h01, 5'h01, 5'h01, 5'h01, 5'h04};
  logic [1:0]  ty [5] = '{2'h3, 2'h1, 2'h3, 2'h1, 2'h3};
  int          error_cnt = 0, check_count = 0, cyc = 0;

  efc_top #(.STALL_WIN_CYC(WIN)) i_efc_top (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .encA(encA), .encB(encB), .homeIn(homeIn),
    .stepPulse(stepPulse), .stepDirUp(stepDirUp), .stepInhibit(stepInhibit),
    .positionValidFlag(positionValidFlag), .motorStallErrorFlag(motorStallErrorFlag),
    .irq(irq));
  efc_enc_model i_efc_enc_model (.clk(clk), .encA(encA), .encB(encB));

  always #2 clk = ~clk;

  task automatic give_verdict;
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic flg(input logic f, input logic e);
    chk({31'h0, f}, {31'h0, e});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Address phase until ready, then data phase until ready; read data taken there.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(d, e);
  endtask
  task automatic setp(input logic [31:0] v);
    wr(EFC_OFS_SETPOS, v);
    wr(EFC_OFS_CONTROL, 32'h0000_0001);
    wt(1);
  endtask
  // The bench stands in for the step generator and honours the inhibit.
  task automatic steps(input int n);
    for (int i = 0; i < n; i++) begin
      stepDirUp <= 1'b1;
      stepPulse <= !stepInhibit;
      @(posedge clk);
      stepPulse <= 1'b0;
      @(posedge clk);
    end
  endtask

  initial begin
    wt(4);
    nrst <= 1'b1;
    wt(1);
    rd(EFC_OFS_CONFIG, 32'h0001_0100);
    rd(EFC_OFS_IRQ_MSK, 32'h0000_0000);
    rd(8'h3C, 32'h0000_0000);
    flg(positionValidFlag, 1'b0);
    wr(EFC_OFS_CONFIG, 32'h0011_0403);
    rd(EFC_OFS_CONFIG, 32'h0001_0100);
    wr(EFC_OFS_CONFIG, 32'h0010_FF03);
    rd(EFC_OFS_CONFIG, 32'h0010_FF03);
    for (int i = 0; i < 5; i++) begin
      i_efc_enc_model.hold = i + 1;
      wr(EFC_OFS_CONFIG, {11'h000, dv[i], mt[i], 6'h00, ty[i]});
      setp(32'h0000_0000);
      i_efc_enc_model.quad(4, 1'b1);
      rd(EFC_OFS_ENC_LO, 32'h4 * mt[i] / dv[i]);
      i_efc_enc_model.quad(4, 1'b0);
      rd(EFC_OFS_ENC_LO, 32'h0000_0000);
    end
    wr(EFC_OFS_CONFIG, 32'h0001_0403);
    setp(32'h0000_0000);
    i_efc_enc_model.quad(1, 1'b0);
    rd(EFC_OFS_ENC_LO, 32'h0000_FFFC);
    rd(EFC_OFS_ENC_HI, 32'h0000_FFFF);
    wr(EFC_OFS_CONFIG, 32'h0001_0102);
    setp(32'h0000_0010);
    i_efc_enc_model.ud(3, 1'b1);
    i_efc_enc_model.ud(1, 1'b0);
    rd(EFC_OFS_ENC_LO, 32'h0000_0012);
    // Marker variant only because the home input carries the marker.
    wr(EFC_OFS_CONFIG, 32'h0001_0101);
    setp(32'h0000_0000);
    i_efc_enc_model.quad(2, 1'b1);
    homeIn <= 1'b1;
    wt(4);
    homeIn <= 1'b0;
    rd(EFC_OFS_MARKER, 32'h0000_0002);
    rd(EFC_OFS_IRQ_ST, 32'h0000_0004);
    rd(EFC_OFS_IRQ_ST, 32'h0000_0000);
    wr(EFC_OFS_CONFIG, 32'h0201_0103);
    setp(32'h0000_0000);
    flg(positionValidFlag, 1'b1);
    i_efc_enc_model.quad(2, 1'b1);
    flg(positionValidFlag, 1'b1);
    i_efc_enc_model.quad(1, 1'b1);
    flg(positionValidFlag, 1'b0);
    flg(stepInhibit, 1'b0);
    flg(irq, 1'b0);
    rd(EFC_OFS_IRQ_ST, 32'h0000_0002);
    wr(EFC_OFS_CONFIG, 32'h0201_0100);
    steps(20);
    wt(2 * WIN);
    flg(motorStallErrorFlag, 1'b0);
    rd(EFC_OFS_MOT_LO, 32'h0000_0014);
    rd(EFC_OFS_MOT_HI, 32'h0000_0000);
    wr(EFC_OFS_IRQ_MSK, 32'h0000_0001);
    // Valid is left low, so the stall is the only event whatever the window phase.
    wr(EFC_OFS_CONFIG, 32'h0201_0103);
    steps(20);
    wt(2 * WIN);
    flg(motorStallErrorFlag, 1'b1);
    flg(stepInhibit, 1'b1);
    flg(irq, 1'b1);
    rd(EFC_OFS_STATUS, 32'h0000_0006);
    rd(EFC_OFS_IRQ_ST, 32'h0000_0001);
    wt(2);
    flg(irq, 1'b0);
    wr(EFC_OFS_CONTROL, 32'h0000_0002);
    wt(1);
    flg(motorStallErrorFlag, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
